// ---- ccgws_pkg.sv ----
// package: register map, field layout and constants of the current waveform sampler
package ccgws_pkg;

    // register addresses on the serial port (7-bit)
    localparam logic [6:0] ADDR_WAVEFORM_SAMPLE_REGISTER   = 7'h01;
    localparam logic [6:0] ADDR_WAVEFORM_MODE_REGISTER = 7'h02;
    localparam logic [6:0] ADDR_MASK    = 7'h03;
    localparam logic [6:0] ADDR_STATUS  = 7'h04;
    localparam logic [6:0] ADDR_GAIN    = 7'h05;
    localparam logic [6:0] ADDR_ASCALE  = 7'h06;
    localparam logic [6:0] ADDR_BSCALE  = 7'h07;
    localparam logic [6:0] ADDR_CSCALE  = 7'h08;

    // command byte: top bit set for a write
    localparam int CMD_WR_BIT = 7;
    localparam logic [5:0] CMD_BITS = 6'h08;

    // analog gain register fields
    localparam int GAIN_IPGA_LSB  = 0;
    localparam int GAIN_RANGE_LSB = 3;
    localparam int GAIN_VPGA_LSB  = 5;
    localparam int GAIN_INTEG_BIT = 7;

    // waveform mode register fields
    localparam int WMODE_SRC_LSB  = 0;
    localparam int WMODE_PHS_LSB  = 3;
    localparam int WMODE_RATE_LSB = 5;
    localparam logic [2:0] SRC_CURRENT = 3'h0;
    localparam logic [1:0] PHS_NONE    = 2'h3;

    // mask and status bit of the sample-ready event
    localparam int SMP_BIT = 0;

    // reset values
    localparam logic [7:0]  GAIN_RST  = 8'h00;
    localparam logic [7:0]  WMODE_RST = 8'h00;
    localparam logic [7:0]  MASK_RST  = 8'h00;
    localparam logic [11:0] SCALE_RST = 12'h000;

    // converter full-scale code and scale shift
    localparam logic signed [23:0] FS_POS = 24'sh2851ec;
    localparam logic signed [23:0] FS_NEG = 24'shd7ae14;
    localparam int SCALE_SHIFT = 12;

    // number of data bytes carried by each register
    function automatic logic [1:0] ccgws_len(input logic [6:0] a);
        unique case (a)
            ADDR_WAVEFORM_SAMPLE_REGISTER:                          ccgws_len = 2'h3;
            ADDR_ASCALE, ADDR_BSCALE, ADDR_CSCALE: ccgws_len = 2'h2;
            default:                             ccgws_len = 2'h1;
        endcase
    endfunction

endpackage

// ---- ccgws_top.sv ----
// current channel gain, waveform sampling and serial register port
//
// Operation
// - gain register bits 1:0 pick current amplifier gain 1, 2 or 4.
// - gain register bits 6:5 pick voltage amplifier gain 1, 2 or 4.
// - gain register bits 4:3 pick current converter range 0.5, 0.25, 0.125 V.
// - gain register bit 7 switches the digital integrator into the current path.
// - one gain setting serves all three phases of a channel.
// - current samples are signed 24-bit words at 26.0 kSPS at most.
// - full-scale current input gives codes from -2642412 to +2642412.
// - each phase current is multiplied by one plus its 12-bit scale over 4096.
// - scale 0x7ff gives about +50 percent, 0x800 gives -50 percent.
// - phase scaling feeds energy, rms and waveform samples alike.
// - source select 000 routes current samples to the waveform register.
// - two-bit phase select picks which phase is routed.
// - energy results keep updating while sampling runs.
// - waveform mode bits 6:5 pick 26.0, 13.0, 6.5 or 3.3 kSPS.
// - with mask bit set, interrupt goes low on each new sample.
// - a 24-bit sample is sent as three bytes, most significant first.
// - interrupt stays low until the host reads the status register.
// - read data leaves on rising serial clock, pin released otherwise.
`timescale 1ns/1ps
module ccgws_top
    import ccgws_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               sys_rst,
    input  wire logic               sclk,
    input  wire logic               cs_n,
    input  wire logic               din,
    output logic                    dout,
    output logic                    dout_oe,
    output logic                    irq_n,
    input  wire logic               adc_stb,
    input  wire logic signed [23:0] cur_adc_a,
    input  wire logic signed [23:0] cur_adc_b,
    input  wire logic signed [23:0] cur_adc_c,
    output logic signed [23:0]      cur_scaled_a,
    output logic signed [23:0]      cur_scaled_b,
    output logic signed [23:0]      cur_scaled_c,
    output logic [2:0]              cur_pga_gain,
    output logic [2:0]              volt_pga_gain,
    output logic [1:0]              cur_adc_range,
    output logic                    integrator_en
);

    ////////////////////////////////////////////////////////////////////////////////
    // state types

    typedef struct packed {
        logic [5:0]  cnt;
        logic [7:0]  cmd;
        logic [23:0] sh;
    } ccgws_rx_t;

    typedef struct packed {
        logic        wr_tog;
        logic        rd_tog;
        logic [6:0]  addr;
        logic [23:0] wdata;
    } ccgws_cap_t;

    typedef struct packed {
        logic dout;
        logic oe;
    } ccgws_tx_t;

    typedef struct packed {
        logic [7:0]             gain;
        logic [2:0][11:0]       scale;
        logic [7:0]             wmode;
        logic [7:0]             mask;
        logic                   smp_flag;
        logic [23:0]            waveform_sample_register;
        logic [2:0]             dec_cnt;
        logic [2:0][23:0]       scaled;
        logic [2:0]             wr_sync;
        logic [2:0]             rd_sync;
        logic [23:0]            rd_hold;
        logic                   irq_n;
        logic [2:0]             ipga;
        logic [2:0]             vpga;
        logic [1:0]             range;
    } ccgws_core_t;

    ccgws_rx_t   rx_ff,   nxt_rx;
    ccgws_cap_t  cap_ff,  nxt_cap;
    ccgws_tx_t   tx_ff,   nxt_tx;
    ccgws_core_t core_ff, nxt_core;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // gain code to factor, reserved code falls back to 1
    function automatic logic [2:0] gain_factor(input logic [1:0] code);
        unique case (code)
            2'h1:    gain_factor = 3'h2;
            2'h2:    gain_factor = 3'h4;
            default: gain_factor = 3'h1;
        endcase
    endfunction

    // clamp a raw code to the converter full scale
    function automatic logic signed [23:0] clamp_fs(input logic signed [23:0] x);
        if (x > FS_POS) begin
            clamp_fs = FS_POS;
        end else if (x < FS_NEG) begin
            clamp_fs = FS_NEG;
        end else begin
            clamp_fs = x;
        end
    endfunction

    // x * (1 + g / 4096), g signed 12-bit
    function automatic logic signed [23:0] apply_scale(input logic signed [23:0] x,
                                                       input logic signed [11:0] g);
        logic signed [35:0] prod;
        logic signed [35:0] sum;
        prod = x * g;
        sum  = 36'(x) + (prod >>> SCALE_SHIFT);
        apply_scale = sum[23:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // serial receive: command and write data sampled on falling sclk

    logic [1:0] rx_len;
    logic [5:0] rx_end;
    assign rx_len = ccgws_len(rx_ff.cmd[6:0]);
    assign rx_end = CMD_BITS + {1'b0, rx_len, 3'h0};

    // shift din in, count bits, hold the command byte
    always_comb begin
        nxt_rx    = rx_ff;
        nxt_rx.sh = {rx_ff.sh[22:0], din};
        if (rx_ff.cnt != 6'h3f) begin
            nxt_rx.cnt = rx_ff.cnt + 6'h01;
        end
        if (rx_ff.cnt == CMD_BITS - 6'h01) begin
            nxt_rx.cmd = {rx_ff.sh[6:0], din};
        end
    end

    // frame state restarts whenever chip select is released
    always_ff @(negedge sclk or posedge cs_n or posedge sys_rst) begin
        if (sys_rst || cs_n) begin
            rx_ff <= '0;
        end else begin
            rx_ff <= nxt_rx;
        end
    end

    // captured request, toggles announce it to the core clock
    always_comb begin
        nxt_cap = cap_ff;
        if (rx_ff.cnt == CMD_BITS - 6'h01 && !rx_ff.sh[6]) begin
            // read request: ask core to load the holding word
            nxt_cap.addr   = {rx_ff.sh[5:0], din};
            nxt_cap.rd_tog = ~cap_ff.rd_tog;
        end else if (rx_ff.cnt >= CMD_BITS && rx_ff.cmd[CMD_WR_BIT] && rx_ff.cnt == rx_end - 6'h01) begin
            nxt_cap.addr   = rx_ff.cmd[6:0];
            nxt_cap.wdata  = {rx_ff.sh[22:0], din};
            nxt_cap.wr_tog = ~cap_ff.wr_tog;
        end
    end

    // request capture survives the end of frame
    always_ff @(negedge sclk or posedge sys_rst) begin
        if (sys_rst) begin
            cap_ff <= '0;
        end else begin
            cap_ff <= nxt_cap;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // serial transmit: read data driven on rising sclk

    logic [5:0] tx_idx;
    assign tx_idx = rx_ff.cnt - CMD_BITS;

    always_comb begin
        nxt_tx = '0;
        if (!rx_ff.cmd[CMD_WR_BIT] && rx_ff.cnt >= CMD_BITS && rx_ff.cnt < rx_end) begin
            nxt_tx.dout = core_ff.rd_hold[5'(6'd23 - tx_idx)];
            nxt_tx.oe   = 1'b1;
        end
    end

    always_ff @(posedge sclk or posedge cs_n or posedge sys_rst) begin
        if (sys_rst || cs_n) begin
            tx_ff <= '0;
        end else begin
            tx_ff <= nxt_tx;
        end
    end

    assign dout    = tx_ff.dout;
    assign dout_oe = tx_ff.oe;

    ////////////////////////////////////////////////////////////////////////////////
    // core clock: registers, scaling, sampling, interrupt

    logic                     wr_ev;
    logic                     rd_ev;
    logic                     smp_ev;
    logic [2:0]               rate_mask;
    logic [1:0]               phs;
    logic [23:0]              rd_val;
    logic [1:0]               rd_len;
    logic signed [2:0][23:0]  adc_in;

    assign adc_in = {cur_adc_c, cur_adc_b, cur_adc_a};
    assign wr_ev  = core_ff.wr_sync[2] ^ core_ff.wr_sync[1];
    assign rd_ev  = core_ff.rd_sync[2] ^ core_ff.rd_sync[1];
    assign phs    = core_ff.wmode[WMODE_PHS_LSB +: 2];
    assign rd_len = ccgws_len(cap_ff.addr);

    always_comb begin
        nxt_core = core_ff;

        // toggle synchronisers
        nxt_core.wr_sync = {core_ff.wr_sync[1:0], cap_ff.wr_tog};
        nxt_core.rd_sync = {core_ff.rd_sync[1:0], cap_ff.rd_tog};

        // per-phase scaling of inputs clamped to full scale, result not clamped
        for (int p = 0; p < 3; p++) begin
            if (adc_stb) begin
                nxt_core.scaled[p] = apply_scale(clamp_fs(adc_in[p]), core_ff.scale[p]);
            end
        end

        // rate code n keeps one sample in 2**n
        unique case (core_ff.wmode[WMODE_RATE_LSB +: 2])
            2'h0:    rate_mask = 3'h0;
            2'h1:    rate_mask = 3'h1;
            2'h2:    rate_mask = 3'h3;
            default: rate_mask = 3'h7;
        endcase

        // current source routed only for code 000
        smp_ev = adc_stb && core_ff.wmode[WMODE_SRC_LSB +: 3] == SRC_CURRENT
                 && phs != PHS_NONE && (core_ff.dec_cnt & rate_mask) == 3'h0;
        if (adc_stb) begin
            nxt_core.dec_cnt = core_ff.dec_cnt + 3'h1;
        end
        if (smp_ev) begin
            // phase pick, scaled path, 24-bit word
            nxt_core.waveform_sample_register = apply_scale(clamp_fs(adc_in[phs]), core_ff.scale[phs]);
        end

        // register reads, status read clears the sample flag
        unique case (cap_ff.addr)
            ADDR_WAVEFORM_SAMPLE_REGISTER:   rd_val = core_ff.waveform_sample_register;
            ADDR_WAVEFORM_MODE_REGISTER: rd_val = {16'h0000, core_ff.wmode};
            ADDR_MASK:    rd_val = {16'h0000, core_ff.mask};
            ADDR_STATUS:  rd_val = {23'h000000, core_ff.smp_flag};
            ADDR_GAIN:    rd_val = {16'h0000, core_ff.gain};
            ADDR_ASCALE:  rd_val = {12'h000, core_ff.scale[0]};
            ADDR_BSCALE:  rd_val = {12'h000, core_ff.scale[1]};
            ADDR_CSCALE:  rd_val = {12'h000, core_ff.scale[2]};
            default:      rd_val = 24'h000000;
        endcase
        if (rd_ev) begin
            // left-align so the top byte leaves first
            nxt_core.rd_hold = rd_val << {(2'h3 - rd_len), 3'h0};
            if (cap_ff.addr == ADDR_STATUS) begin
                nxt_core.smp_flag = 1'b0;
            end
        end
        if (smp_ev) begin
            // new sample wins over a clear in the same cycle
            nxt_core.smp_flag = 1'b1;
        end

        // register writes, unmapped and read-only addresses ignored
        if (wr_ev) begin
            unique case (cap_ff.addr)
                ADDR_WAVEFORM_MODE_REGISTER: nxt_core.wmode = cap_ff.wdata[7:0];
                ADDR_MASK:    nxt_core.mask = cap_ff.wdata[7:0];
                ADDR_GAIN:    nxt_core.gain = cap_ff.wdata[7:0];
                // signed 12-bit scale, +-50 percent span
                ADDR_ASCALE:  nxt_core.scale[0] = cap_ff.wdata[11:0];
                ADDR_BSCALE:  nxt_core.scale[1] = cap_ff.wdata[11:0];
                ADDR_CSCALE:  nxt_core.scale[2] = cap_ff.wdata[11:0];
                default:      nxt_core.wmode = core_ff.wmode;
            endcase
        end

        // gain decode, shared by all phases
        nxt_core.ipga = gain_factor(nxt_core.gain[GAIN_IPGA_LSB +: 2]);
        nxt_core.vpga = gain_factor(nxt_core.gain[GAIN_VPGA_LSB +: 2]);
        // range code 11 reserved, treated as widest
        nxt_core.range = (nxt_core.gain[GAIN_RANGE_LSB +: 2] == 2'h3) ? 2'h0
                       : nxt_core.gain[GAIN_RANGE_LSB +: 2];

        // masked sample flag pulls interrupt low
        nxt_core.irq_n = ~(nxt_core.smp_flag && nxt_core.mask[SMP_BIT]);
    end

    // core register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            core_ff       <= '0;
            core_ff.gain  <= GAIN_RST;
            core_ff.wmode <= WMODE_RST;
            core_ff.mask  <= MASK_RST;
            core_ff.scale <= {3{SCALE_RST}};
            core_ff.ipga  <= 3'h1;
            core_ff.vpga  <= 3'h1;
            core_ff.irq_n <= 1'b1;
        end else begin
            core_ff <= nxt_core;
        end
    end

    // outputs straight from flip-flops
    assign irq_n         = core_ff.irq_n;
    assign cur_scaled_a  = core_ff.scaled[0];
    assign cur_scaled_b  = core_ff.scaled[1];
    assign cur_scaled_c  = core_ff.scaled[2];
    assign cur_pga_gain  = core_ff.ipga;
    assign volt_pga_gain = core_ff.vpga;
    assign cur_adc_range = core_ff.range;
    assign integrator_en = core_ff.gain[GAIN_INTEG_BIT];

endmodule

// ---- ccgws_chk.sv ----
// checker: port-level properties of the current waveform sampler
`timescale 1ns/1ps
module ccgws_chk
    import ccgws_pkg::*;
(
    input wire logic               core_clk,
    input wire logic               sys_rst,
    input wire logic               cs_n,
    input wire logic               dout_oe,
    input wire logic               irq_n,
    input wire logic               adc_stb,
    input wire logic signed [23:0] cur_adc_a,
    input wire logic signed [23:0] cur_scaled_a,
    input wire logic signed [23:0] cur_scaled_b,
    input wire logic signed [23:0] cur_scaled_c,
    input wire logic [2:0]         cur_pga_gain,
    input wire logic [2:0]         volt_pga_gain,
    input wire logic [1:0]         cur_adc_range,
    input wire logic               integrator_en
);
    // all checks sit in the core domain
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////
    a_rst_state: assert property ($fell(sys_rst) |-> irq_n && !integrator_en
        && cur_pga_gain == 3'h1 && volt_pga_gain == 3'h1 && cur_adc_range == 2'h0)
        else $error("state after reset wrong");
    a_gain_legal: assert property ((cur_pga_gain inside {3'h1, 3'h2, 3'h4})
        && (volt_pga_gain inside {3'h1, 3'h2, 3'h4})) else $error("gain factor illegal");
    a_range_legal: assert property (cur_adc_range != 2'h3)
        else $error("range code illegal");
    a_scaled_hold: assert property (!adc_stb |=> $stable(cur_scaled_a)
        && $stable(cur_scaled_b) && $stable(cur_scaled_c)) else $error("scaled moved");
    a_zero_in: assert property (adc_stb && cur_adc_a == 24'sh0 |=>
        cur_scaled_a == 24'sh0) else $error("zero input not zero");
    a_scale_bound: assert property (adc_stb |=> cur_scaled_a <= 24'sd3963618
        && cur_scaled_a >= -24'sd3963618) else $error("scaled out of range");
    a_sign_kept: assert property (adc_stb && cur_adc_a > 24'sh0 |=>
        cur_scaled_a >= 24'sh0) else $error("sign flipped");
    a_irq_cause: assert property ($fell(irq_n) |-> $past(adc_stb))
        else $error("irq without sample");
    a_irq_release: assert property ($rose(irq_n) |-> $past(cs_n) == 1'b0)
        else $error("irq released outside frame");
    a_oe_chip: assert property (cs_n |-> !dout_oe)
        else $error("dout driven while deselected");
endmodule
bind ccgws_top ccgws_chk u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .cs_n(cs_n),
    .dout_oe(dout_oe), .irq_n(irq_n), .adc_stb(adc_stb), .cur_adc_a(cur_adc_a),
    .cur_scaled_a(cur_scaled_a), .cur_scaled_b(cur_scaled_b), .cur_scaled_c(cur_scaled_c),
    .cur_pga_gain(cur_pga_gain), .volt_pga_gain(volt_pga_gain),
    .cur_adc_range(cur_adc_range), .integrator_en(integrator_en));

// ---- ccgws_host.sv ----
// partner: host controller driving the serial register port
`timescale 1ns/1ps
module ccgws_host (
    output logic     sclk,
    output logic     cs_n,
    output logic     din,
    input wire logic dout,
    input wire logic dout_oe
);
    // released pin shows the opposite level, never a stale bit
    wire sdo = dout_oe ? dout : ~dout;
    // serial clock idles high, stands still outside frames
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din  = 1'b0;
    end
    // one frame: command, then nb bytes most significant first
    task automatic xfer(input logic [7:0] cmd, input int nb, input logic [23:0] wd,
                        output logic [23:0] rd);
        logic [31:0] sh;
        sh = {cmd, 24'(wd << (8 * (3 - nb)))};
        rd = 24'h0;
        #1.3;
        cs_n = 1'b0;
        for (int k = 0; k < 8 + 8 * nb; k++) begin
            din = sh[31 - k];
            #24;
            sclk = 1'b0;
            if (k >= 8) rd = {rd[22:0], sdo};
            // gap lets the core load the read word
            #(k == 7 ? 72 : 24);
            sclk = 1'b1;
        end
        #24;
        cs_n = 1'b1;
        din = ~din;
        #48;
    endtask
endmodule

// ---- ccgws_tb_top.sv ----
// testbench: host model, converter stimulus and reference model
`timescale 1ns/1ps
module ccgws_tb_top
    import ccgws_pkg::*;
;
    logic              core_clk, sys_rst, adc_stb;
    logic signed [23:0] adc [3];
    wire logic signed [23:0] scl [3];
    wire logic         sclk, cs_n, din, dout, dout_oe, irq_n, integrator_en;
    wire logic [2:0]   cur_pga_gain, volt_pga_gain;
    wire logic [1:0]   cur_adc_range;
    longint            gs [3];
    logic [23:0]       ex [3];
    int                n_fail, checks_done, cyc;
    ccgws_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n),
        .din(din), .dout(dout), .dout_oe(dout_oe), .irq_n(irq_n), .adc_stb(adc_stb),
        .cur_adc_a(adc[0]), .cur_adc_b(adc[1]), .cur_adc_c(adc[2]),
        .cur_scaled_a(scl[0]), .cur_scaled_b(scl[1]), .cur_scaled_c(scl[2]),
        .cur_pga_gain(cur_pga_gain), .volt_pga_gain(volt_pga_gain),
        .cur_adc_range(cur_adc_range), .integrator_en(integrator_en));
    ccgws_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe));
    ////////////////////
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks_done %0d n_fail %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // reference: clamp to full scale, then x + floor(x*g/4096)
    function automatic logic [23:0] mscale(input longint x, input longint g);
        longint c;
        c = (x > 2642412) ? 2642412 : (x < -2642412) ? -2642412 : x;
        return 24'(c + ((c * g) >>> 12));
    endfunction
    task automatic acc(input logic wr, input logic [6:0] a, input int nb,
                       input logic [23:0] d, output logic [23:0] r);
        host.xfer({wr, a}, nb, d, r);
        repeat (10) @(posedge core_clk);
        #1;
    endtask
    // one converter sample on all phases, scaled outputs compared
    task automatic strobe(input logic [23:0] x);
        logic signed [23:0] v [3];
        v = '{x, -x, 24'($urandom)};
        @(posedge core_clk);
        adc_stb <= 1'b1;
        for (int p = 0; p < 3; p++) adc[p] <= v[p];
        @(posedge core_clk);
        adc_stb <= 1'b0;
        #1;
        for (int p = 0; p < 3; p++) begin
            ex[p] = mscale(v[p], gs[p]);
            chk("scaled", scl[p], ex[p]);
        end
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    ////////////////////
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // hang guard
    initial begin
        cyc = 0;
        forever @(posedge core_clk) begin
            cyc++;
            if (cyc == 60000) begin
                n_fail++;
                finish_test();
            end
        end
    end
    initial begin
        logic [23:0] r;
        logic [11:0] sv [3];
        logic [23:0] lst [5];
        logic [7:0]  gb;
        logic [2:0]  ef;
        int          n;
        sys_rst = 1'b1;
        adc_stb = 1'b0;
        adc = '{default: 24'sh0};
        gs = '{default: 0};
        lst = '{24'h7fffff, 24'h2851ec, 24'h800000, 24'h000000, 24'h000001};
        void'($urandom(40));
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk("reset", 24'({cur_pga_gain, volt_pga_gain, cur_adc_range, integrator_en, irq_n,
            dout_oe}), 24'({3'h1, 3'h1, 2'h0, 1'b0, 1'b1, 1'b0}));
        for (int i = 0; i < 4; i++) begin
            gb = {i[0], i[1:0], i[1:0], 1'b0, i[1:0]};
            acc(1'b1, ADDR_GAIN, 1, 24'(gb), r);
            ef = (i == 1) ? 3'h2 : (i == 2) ? 3'h4 : 3'h1;
            chk("gain", 24'({cur_pga_gain, volt_pga_gain, cur_adc_range, integrator_en}),
                24'({ef, ef, (i == 3) ? 2'h0 : 2'(i), i[0]}));
            acc(1'b0, ADDR_GAIN, 1, 24'h0, r);
            chk("gain_rd", r, 24'(gb));
        end
        sv = '{12'h7ff, 12'h800, 12'($urandom)};
        for (int p = 0; p < 3; p++) begin
            acc(1'b1, ADDR_ASCALE + 7'(p), 2, 24'(sv[p]), r);
            gs[p] = longint'(signed'(sv[p]));
            acc(1'b0, ADDR_ASCALE + 7'(p), 2, 24'h0, r);
            chk("scale_rd", 24'(r[11:0]), 24'(sv[p]));
        end
        for (int k = 0; k < 11; k++) strobe(k < 5 ? lst[k] : 24'($urandom));
        acc(1'b0, ADDR_STATUS, 1, 24'h0, r);
        acc(1'b1, ADDR_MASK, 1, 24'h1, r);
        for (int p = 0; p < 3; p++) begin
            acc(1'b1, ADDR_WAVEFORM_MODE_REGISTER, 1, 24'({2'h0, 2'(p), 3'h0}), r);
            strobe(24'($urandom));
            chk("irq_low", 24'(irq_n), 24'h0);
            acc(1'b0, ADDR_WAVEFORM_SAMPLE_REGISTER, 3, 24'h0, r);
            chk("waveform_sample_register", r, ex[p]);
            acc(1'b0, ADDR_STATUS, 1, 24'h0, r);
            chk("status", r, 24'h1);
            chk("irq_clr", 24'(irq_n), 24'h1);
        end
        for (int q = 0; q < 4; q++) begin
            acc(1'b1, ADDR_WAVEFORM_MODE_REGISTER, 1, 24'({2'(q), 2'h0, 3'h0}), r);
            n = 0;
            for (int k = 0; k < 16; k++) begin
                strobe(24'($urandom));
                if (irq_n === 1'b0) begin
                    n++;
                    acc(1'b0, ADDR_STATUS, 1, 24'h0, r);
                end
            end
            chk("rate", 24'(n), 24'(16 >> q));
        end
        acc(1'b1, ADDR_WAVEFORM_MODE_REGISTER, 1, 24'({2'h0, 2'h3, 3'h0}), r);
        strobe(24'($urandom));
        chk("no_phase", 24'(irq_n), 24'h1);
        acc(1'b1, ADDR_WAVEFORM_MODE_REGISTER, 1, 24'h000001, r);
        strobe(24'($urandom));
        chk("src_other", 24'(irq_n), 24'h1);
        acc(1'b1, ADDR_MASK, 1, 24'h0, r);
        acc(1'b1, ADDR_WAVEFORM_MODE_REGISTER, 1, 24'h0, r);
        strobe(24'($urandom));
        chk("masked", 24'(irq_n), 24'h1);
        acc(1'b0, ADDR_STATUS, 1, 24'h0, r);
        chk("status_m", r, 24'h1);
        acc(1'b1, ADDR_WAVEFORM_SAMPLE_REGISTER, 3, 24'h123456, r);
        acc(1'b0, ADDR_WAVEFORM_SAMPLE_REGISTER, 3, 24'h0, r);
        chk("waveform_sample_register_ro", r, ex[0]);
        acc(1'b0, 7'h7f, 1, 24'h0, r);
        chk("unmapped", r, 24'h0);
        finish_test();
    end
endmodule
